/* rtl/rrs_sync.sv */
// constants package and the two-flop pin synchroniser for the reset/strap block
package rrs_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int STRAP_DELAY_NS = 1500;
  localparam int STRAP_CYCLES = (STRAP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] STRAP_LAST = 8'(STRAP_CYCLES - 1);
  localparam int QUIET_MS = 500;
  localparam int QUIET_CYCLES = (QUIET_MS * 1000000) / CLK_PERIOD_NS;
  localparam int QUIET_W = 26;
  // ==========================================================
  // pin counts, field widths and reset values
  localparam int GP_PINS = 20;
  localparam int STRAP_PINS = 8;
  localparam int TEST_MODE_SELECT_W = 3;
  localparam logic [TEST_MODE_SELECT_W-1:0] TEST_MODE_SELECT_NORMAL = 3'h0;
  localparam logic [19:0] GP_UNUSED_MASK_RST = 20'h00000;
  localparam logic SYNC_RST_VAL = 1'b0;

  typedef enum logic [1:0] {
    RRS_S_RESET = 2'b00,
    RRS_S_STRAP = 2'b01,
    RRS_S_RUN = 2'b10
  } rrs_state_t;
endpackage : rrs_pkg

`timescale 1ns/100ps

module rrs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // first stage is read only by the second stage
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta_reg <= {WIDTH{rrs_pkg::SYNC_RST_VAL}};
      sync_out <= {WIDTH{rrs_pkg::SYNC_RST_VAL}};
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : rrs_sync

/* rtl/rrs_reset_release.sv */
// power-on reset release, output safing, test strap sampling and bus quiet timer
// ==========================================================
`timescale 1ns/100ps

module rrs_reset_release #(
  parameter int QUIET_CYCLES = rrs_pkg::QUIET_CYCLES,
  parameter logic [19:0] GP_UNUSED_MASK = rrs_pkg::GP_UNUSED_MASK_RST
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic power_on_reset_n,
  input wire logic mirror_park_request_n,
  input wire logic [7:0] test_strap_in,
  input wire logic [7:0] test_obs_data,
  input wire logic core_flash_clock,
  input wire logic core_flash_out,
  input wire logic core_flash_select0_n,
  input wire logic core_flash_select1_n,
  input wire logic [19:0] core_gp_out,
  input wire logic [19:0] core_gp_oe,
  input wire logic core_light_select0,
  input wire logic core_light_select1,
  input wire logic core_mirror_enable_n,
  output logic flash_serial_clock,
  output logic flash_serial_clock_oe,
  output logic flash_serial_out,
  output logic flash_serial_out_oe,
  output logic flash_select0_n,
  output logic flash_select0_n_oe,
  output logic flash_select1_n,
  output logic flash_select1_n_oe,
  output logic [19:0] general_pins_out,
  output logic [19:0] general_pins_oe,
  output logic light_source_select0,
  output logic light_source_select1,
  output logic mirror_array_enable_n,
  output logic [7:0] test_strap_out,
  output logic [7:0] test_strap_oe,
  output logic [2:0] test_mode_select,
  output logic functional_mode,
  output logic config_start,
  output logic bus_quiet_done
);
  // ==========================================================
  // pin synchronisers
  logic por_s;
  logic park_s;
  logic [7:0] strap_s;

  // host keeps the pin low until power is good, so a sampled high means released
  rrs_sync #(.WIDTH(10)) u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .async_in({power_on_reset_n, mirror_park_request_n, test_strap_in}),
    .sync_out({por_s, park_s, strap_s})
  );

  // pin reset seen two cycles late; outputs safe one cycle after that
  logic in_rst;
  assign in_rst = sys_rst | ~por_s;

  // ==========================================================
  // sequencer state
  rrs_pkg::rrs_state_t state_reg, state_next;
  logic por_q_reg, por_q_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [2:0] test_mode_select_reg, test_mode_select_next;
  logic start_reg, start_next;
  logic [rrs_pkg::QUIET_W-1:0] quiet_reg, quiet_next;
  logic quiet_done_reg, quiet_done_next;
  logic strap_done;

  assign strap_done = (state_reg == rrs_pkg::RRS_S_STRAP) && (cnt_reg == rrs_pkg::STRAP_LAST);

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    test_mode_select_next = test_mode_select_reg;
    start_next = 1'b0;
    por_q_next = in_rst ? 1'b0 : por_s;
    quiet_next = quiet_reg;
    quiet_done_next = quiet_done_reg;
    if (in_rst) begin
      state_next = rrs_pkg::RRS_S_RESET;
      cnt_next = 8'h00;
      test_mode_select_next = rrs_pkg::TEST_MODE_SELECT_NORMAL;
    end else begin
      case (state_reg)
        rrs_pkg::RRS_S_RESET: begin
          if (por_s && !por_q_reg) begin
            state_next = rrs_pkg::RRS_S_STRAP;
            start_next = 1'b1;
            cnt_next = 8'h00;
          end
        end
        rrs_pkg::RRS_S_STRAP: begin
          if (strap_done) begin
            state_next = rrs_pkg::RRS_S_RUN;
            // a pulled-up pin on strap_s[2:0] here selects a test mode
            test_mode_select_next = strap_s[2:0];
          end else begin
            cnt_next = cnt_reg + 8'h01;
          end
        end
        rrs_pkg::RRS_S_RUN: begin
          state_next = rrs_pkg::RRS_S_RUN;
        end
        default: begin
          state_next = rrs_pkg::RRS_S_RESET;
        end
      endcase
    end
    // host-side quiet period, restarted whenever reset or park drops
    if (in_rst || !park_s) begin
      quiet_next = '0;
      quiet_done_next = 1'b0;
    end else if (!quiet_done_reg) begin
      if (quiet_reg == rrs_pkg::QUIET_W'(QUIET_CYCLES - 1)) begin
        quiet_done_next = 1'b1;
      end else begin
        quiet_next = quiet_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg <= rrs_pkg::RRS_S_RESET;
      por_q_reg <= 1'b0;
      cnt_reg <= 8'h00;
      test_mode_select_reg <= rrs_pkg::TEST_MODE_SELECT_NORMAL;
      start_reg <= 1'b0;
      quiet_reg <= '0;
      quiet_done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      por_q_reg <= por_q_next;
      cnt_reg <= cnt_next;
      test_mode_select_reg <= test_mode_select_next;
      start_reg <= start_next;
      quiet_reg <= quiet_next;
      quiet_done_reg <= quiet_done_next;
    end
  end

  // ==========================================================
  // pin outputs, all registered
  logic [3:0] fl_oe_next;
  logic [19:0] gp_oe_next;
  logic [2:0] safe_next;
  logic [7:0] tp_oe_next;
  logic func_next;

  always_comb begin
    fl_oe_next = in_rst ? 4'h0 : 4'hf;
    gp_oe_next = in_rst ? 20'h00000 : (core_gp_oe | GP_UNUSED_MASK);
    // forced low rather than floated: these have no board pulls to rely on
    safe_next = in_rst ? 3'h0 : {core_mirror_enable_n, core_light_select1,
                                 core_light_select0};
    tp_oe_next = (!in_rst && state_next == rrs_pkg::RRS_S_RUN) ? 8'hff : 8'h00;
    func_next = !in_rst && (state_reg == rrs_pkg::RRS_S_RUN)
                && (test_mode_select_reg == rrs_pkg::TEST_MODE_SELECT_NORMAL);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      {flash_serial_clock_oe, flash_serial_out_oe, flash_select0_n_oe, flash_select1_n_oe} <= 4'h0;
      general_pins_oe <= 20'h00000;
      {mirror_array_enable_n, light_source_select1, light_source_select0} <= 3'h0;
      test_strap_oe <= 8'h00;
      functional_mode <= 1'b0;
      flash_serial_clock <= 1'b0;
      flash_serial_out <= 1'b0;
      flash_select0_n <= 1'b1;
      flash_select1_n <= 1'b1;
      general_pins_out <= 20'h00000;
      test_strap_out <= 8'h00;
    end else begin
      {flash_serial_clock_oe, flash_serial_out_oe, flash_select0_n_oe, flash_select1_n_oe} <=
        fl_oe_next;
      general_pins_oe <= gp_oe_next;
      {mirror_array_enable_n, light_source_select1, light_source_select0} <= safe_next;
      test_strap_oe <= tp_oe_next;
      functional_mode <= func_next;
      flash_serial_clock <= core_flash_clock;
      flash_serial_out <= core_flash_out;
      flash_select0_n <= core_flash_select0_n;
      flash_select1_n <= core_flash_select1_n;
      general_pins_out <= core_gp_out;
      test_strap_out <= test_obs_data;
    end
  end

  assign test_mode_select = test_mode_select_reg;
  assign config_start = start_reg;
  assign bus_quiet_done = quiet_done_reg;

  // ==========================================================
  // assertions
  AST_CFG_START: assert property (@(posedge core_clk) disable iff (sys_rst)
    (por_s && !por_q_reg && state_reg == rrs_pkg::RRS_S_RESET)
      |=> config_start ##1 !config_start)
    else $error("config start did not pulse on reset release");
  AST_TRISTATE: assert property (@(posedge core_clk) disable iff (sys_rst)
    !por_s |=> !flash_serial_clock_oe && !flash_serial_out_oe && general_pins_oe == 20'h00000)
    else $error("flash or general pins driven during reset");
  AST_FORCE_LOW: assert property (@(posedge core_clk) disable iff (sys_rst)
    !por_s |=> !light_source_select0 && !light_source_select1 && !mirror_array_enable_n)
    else $error("light selects or mirror enable not low during reset");
  AST_INACTIVE: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!por_s)[*2] |-> !flash_select0_n_oe && !flash_select1_n_oe && !functional_mode)
    else $error("active output during reset");
  AST_STRAP_HIZ: assert property (@(posedge core_clk) disable iff (sys_rst)
    config_start |-> (test_strap_oe == 8'h00)[*8])
    else $error("test pins driven before strap sampling");
  AST_STRAP_DRIVE: assert property (@(posedge core_clk) disable iff (sys_rst)
    (strap_done && !in_rst)
      |=> test_strap_oe == 8'hff ##1 (test_strap_oe == 8'hff || $past(in_rst)))
    else $error("test pins not driven after sampling");
  AST_TEST_MODE_SELECT: assert property (@(posedge core_clk) disable iff (sys_rst)
    (strap_done && !in_rst) |=> test_mode_select == $past(strap_s[2:0]))
    else $error("test mode select does not match sampled pins");
  AST_UNUSED_OUT: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!in_rst && state_reg == rrs_pkg::RRS_S_RUN)
      |=> (general_pins_oe & GP_UNUSED_MASK) == GP_UNUSED_MASK)
    else $error("unused general pins not driven after release");
  AST_NORMAL: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!in_rst && state_reg == rrs_pkg::RRS_S_RUN && test_mode_select == 3'h0) |=> functional_mode)
    else $error("zero test mode did not select normal operation");
  AST_QUIET: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!park_s || !por_s) |=> !bus_quiet_done)
    else $error("quiet period reported done while park or reset low");

  COV_RELEASE: cover property (@(posedge core_clk) disable iff (sys_rst) config_start);
  COV_RUN_NORMAL: cover property (@(posedge core_clk) disable iff (sys_rst) $rose(functional_mode));
  COV_TEST_MODE: cover property (@(posedge core_clk) disable iff (sys_rst)
    state_reg == rrs_pkg::RRS_S_RUN && test_mode_select != 3'h0);
  COV_QUIET: cover property (@(posedge core_clk) disable iff (sys_rst) $rose(bus_quiet_done));
endmodule : rrs_reset_release

/* verif/rrs_host_model.sv */
// host-side model: reset and park pins, test pin pulls, control bus start gate
`timescale 1ns/100ps

module rrs_host_model #(
  parameter int QUIET = 20
) (
  input wire logic core_clk,
  input wire logic supplies_ok,
  input wire logic park_release,
  input wire logic [7:0] strap_pull,
  input wire logic [7:0] test_strap_out,
  input wire logic [7:0] test_strap_oe,
  output logic power_on_reset_n,
  output logic mirror_park_request_n,
  output logic [7:0] test_strap_in,
  output logic bus_start
);
  int quiet_cnt = 0;
  // ==========================================================
  // pins
  assign power_on_reset_n = supplies_ok;
  assign mirror_park_request_n = park_release;
  // released test pins fall to the pulldown unless a pull is commanded
  assign test_strap_in = (test_strap_oe & test_strap_out) | (~test_strap_oe & strap_pull);
  // ==========================================================
  // own quiet timer, independent of the device flag
  always @(posedge core_clk) begin
    if (!(power_on_reset_n && mirror_park_request_n)) begin
      quiet_cnt <= 0;
    end else if (quiet_cnt < QUIET) begin
      quiet_cnt <= quiet_cnt + 1;
    end
  end
  assign bus_start = (quiet_cnt == QUIET);
endmodule : rrs_host_model

/* verif/test_rrs_reset_release.sv */
// self-checking bench for reset release, output safing and strap sampling
`timescale 1ns/100ps

module test_rrs_reset_release;
  localparam int QC = 20;
  localparam logic [19:0] GPM = 20'h0000f;
  logic core_clk, sys_rst, supplies_ok, park_release, bus_start;
  logic power_on_reset_n, mirror_park_request_n;
  logic [7:0] strap_pull, test_strap_in, test_obs_data, test_strap_out, test_strap_oe;
  logic core_flash_clock, core_flash_out, core_flash_select0_n, core_flash_select1_n;
  logic [19:0] core_gp_out, core_gp_oe, general_pins_out, general_pins_oe;
  logic core_light_select0, core_light_select1, core_mirror_enable_n;
  logic flash_serial_clock, flash_serial_clock_oe, flash_serial_out, flash_serial_out_oe;
  logic flash_select0_n, flash_select0_n_oe, flash_select1_n, flash_select1_n_oe;
  logic light_source_select0, light_source_select1, mirror_array_enable_n;
  logic [2:0] test_mode_select;
  logic functional_mode, config_start, bus_quiet_done;
  int err_total = 0;
  int checks_done = 0;

  rrs_reset_release #(.QUIET_CYCLES(QC), .GP_UNUSED_MASK(GPM)) DUT (.*);
  rrs_host_model #(.QUIET(QC)) host (.*);

  // ==========================================================
  // helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic pick(input int sel);
    case (sel)
      0: return config_start;
      1: return test_strap_oe[0];
      2: return bus_quiet_done;
      default: return bus_start;
    endcase
  endfunction : pick

  // bounded so a stuck flag cannot hang the run
  task automatic wait_hi(input int sel, output int n);
    n = 0;
    while (pick(sel) !== 1'b1 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
  endtask : wait_hi

  task automatic check_safe();
    check("pin oe", {flash_serial_clock_oe, flash_serial_out_oe, flash_select0_n_oe,
      flash_select1_n_oe, general_pins_oe}, '0);
    check("forced lows", {light_source_select0, light_source_select1, mirror_array_enable_n}, '0);
    check("strap oe", test_strap_oe, '0);
    check("active", {config_start, functional_mode, bus_quiet_done, test_mode_select}, '0);
  endtask : check_safe

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  // ==========================================================
  // scenarios
  task automatic t_release(input logic [7:0] pat);
    int n;
    strap_pull = pat;
    supplies_ok = 1'b1;
    wait_hi(0, n);
    check("start delay", n, 3);
    wait_hi(1, n);
    strap_pull = 8'h00;
    check("sample time", (n >= 148 && n <= 154), 1);
    check("strap oe", test_strap_oe, 8'hff);
    check("mode select", test_mode_select, pat[2:0]);
    @(negedge core_clk);
    check("functional", functional_mode, pat[2:0] == 3'h0);
    check("strap out", test_strap_out, test_obs_data);
    check("gp oe", general_pins_oe, core_gp_oe | GPM);
    check("flash", {flash_serial_clock_oe, flash_serial_clock}, {1'b1, core_flash_clock});
    check("light", light_source_select0, core_light_select0);
    check("light1", light_source_select1, core_light_select1);
    check("mirror", mirror_array_enable_n, core_mirror_enable_n);
    check("out oe", flash_serial_out_oe, 1'b1);
    check("select oe", {flash_select0_n_oe, flash_select1_n_oe}, 2'h3);
    check("flash out", flash_serial_out, core_flash_out);
    check("select0", flash_select0_n, core_flash_select0_n);
    check("select1", flash_select1_n, core_flash_select1_n);
    check("gp out", general_pins_out, core_gp_out);
    check("quiet parked", bus_quiet_done, 1'b0);
    supplies_ok = 1'b0;
    repeat (4) @(negedge core_clk);
    check_safe();
    $display("test release %h done", pat);
  endtask : t_release

  task automatic t_abort();
    supplies_ok = 1'b1;
    strap_pull = 8'h07;
    repeat (50) @(negedge core_clk);
    supplies_ok = 1'b0;
    repeat (4) @(negedge core_clk);
    check_safe();
    strap_pull = 8'h00;
    $display("test abort done");
  endtask : t_abort

  task automatic t_quiet();
    int n;
    park_release = 1'b1;
    supplies_ok = 1'b1;
    wait_hi(3, n);
    check("quiet host", n, QC);
    check("quiet early", bus_quiet_done, 1'b0);
    wait_hi(2, n);
    // two synchroniser stages against the host's unsynchronised count
    check("quiet time", n, 2);
    park_release = 1'b0;
    repeat (4) @(negedge core_clk);
    check("quiet drop", bus_quiet_done, 1'b0);
    sys_rst = 1'b1;
    repeat (3) @(negedge core_clk);
    check_safe();
    sys_rst = 1'b0;
    supplies_ok = 1'b0;
    repeat (2) @(negedge core_clk);
    check_safe();
    $display("test quiet done");
  endtask : t_quiet

  // ==========================================================
  // clock, main sequence, watchdog
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    sys_rst = 1'b1;
    supplies_ok = 1'b0;
    park_release = 1'b0;
    strap_pull = 8'h00;
    test_obs_data = 8'ha5;
    {core_flash_clock, core_flash_out} = 2'h3;
    {core_flash_select0_n, core_flash_select1_n} = 2'h0;
    core_gp_out = 20'hfffff;
    core_gp_oe = 20'h0f0f0;
    {core_light_select0, core_light_select1, core_mirror_enable_n} = 3'h7;
    repeat (20) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge core_clk);
    check_safe();
    $display("test reset hold done");
    for (int i = 0; i < 8; i++) begin
      t_release({5'(i * 3), 3'(i)});
    end
    t_abort();
    t_quiet();
    print_verdict();
  end

  // whole run is about 1400 cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    err_total++;
    print_verdict();
  end
endmodule : test_rrs_reset_release
